// ===== rtl/ssp_pkg.sv
package ssp_pkg;

   // =====================================================
   // data path geometry
   localparam int FIFO_WIDTH = 16;
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_IRQ_LEVEL = FIFO_DEPTH / 2;
   localparam int NUM_TARGETS = 4;
   localparam int TGT_W = 2;
   localparam int MIN_WORD_LEN = 4;
   localparam int MAX_WORD_LEN = 16;

   // =====================================================
   // per-target settings word layout
   localparam int SET_LEN_LSB = 0;
   localparam int SET_LEN_W = 4;
   localparam int SET_FMT_BIT = 4;
   localparam int SET_MODE_LSB = 5;
   localparam int SET_W = 7;
   localparam logic [SET_LEN_W-1:0] LEN_M1_MIN = 4'h3;

   // =====================================================
   // clock generator defaults and reset values
   localparam int PRESCALE_W_DEF = 8;
   localparam int DIV_W_DEF = 8;
   localparam logic SCLK_IDLE = 1'b0;

   // =====================================================
   // modes and states
   typedef enum logic [1:0] {
      MODE_MASTER_NORMAL = 2'h0,
      MODE_MASTER_SEQ = 2'h1,
      MODE_SLAVE = 2'h2,
      MODE_SLAVE_ALT = 2'h3
   } op_mode_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_LEAD = 2'h1,
      ST_SHIFT = 2'h3,
      ST_TRAIL = 2'h2
   } xfer_state_t;

endpackage

// ===== rtl/ssp_fifo.sv
module ssp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [$clog2(DEPTH):0] level
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   assign in_ready = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_q];
   assign level = cnt_q;

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   // depth is a power of two, pointers wrap naturally
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cnt_q <= '0;
      end else if (push && !pop) begin
         cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);

   fifo_no_overflow_a: assert property (cnt_q == (AW+1)'(DEPTH) |=> cnt_q != '0)
      else $error("fifo count wrapped past full");
endmodule

// ===== rtl/synchronous_serial_port.sv
module synchronous_serial_port
   import ssp_pkg::*;
#(
   parameter int PRESCALE_W = PRESCALE_W_DEF,
   parameter int DIV_W = DIV_W_DEF,
   parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic port_enable,
   input wire logic loopback_en,
   input wire logic [PRESCALE_W-1:0] prescale,
   input wire logic [DIV_W-1:0] bit_rate_div,
   input wire logic [SET_W-1:0] per_target_settings [NUM_TARGETS],
   input wire logic [TGT_W-1:0] normal_target,
   input wire logic [TGT_W-1:0] last_seq_target,
   input wire logic [FIFO_WIDTH-1:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic [FIFO_WIDTH-1:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   input wire logic tx_irq_en,
   input wire logic rx_irq_en,
   input wire logic overrun_irq_en,
   input wire logic overrun_clear,
   output logic overrun_flag,
   output logic busy,
   output logic combined_irq_out,
   input wire logic sclk_in,
   output logic sclk_out,
   output logic sclk_oe,
   input wire logic [NUM_TARGETS-1:0] target_select_line_in,
   output logic [NUM_TARGETS-1:0] target_select_line_out,
   output logic [NUM_TARGETS-1:0] target_select_line_oe,
   input wire logic serial_data_in_pin,
   output logic serial_data_out_pin
);
   localparam int LVW = $clog2(FIFO_DEPTH_P) + 1;

   // =====================================================
   // declarations
   xfer_state_t state_q;
   op_mode_t mode;
   logic slave;
   logic seq_mode;
   logic [TGT_W-1:0] target_q;
   logic [TGT_W-1:0] next_tgt;
   logic [SET_W-1:0] start_set;
   logic [SET_LEN_W-1:0] len_raw;
   logic [SET_LEN_W-1:0] len_next;
   logic [SET_LEN_W-1:0] len_m1_q;
   logic fp_q;
   logic [PRESCALE_W-1:0] presc_q;
   logic [DIV_W-1:0] div_q;
   logic tick;
   logic sclk_q;
   logic sclk_run;
   logic [2:0] sync1_q;
   logic [2:0] sync2_q;
   logic sclk_d3_q;
   logic select_line_zero;
   logic s_rise;
   logic s_fall;
   logic m_rise;
   logic m_fall;
   logic rise_e;
   logic fall_e;
   logic din_eff;
   logic sample_q;
   logic [FIFO_WIDTH-1:0] shift_q;
   logic [FIFO_WIDTH-1:0] shift_d;
   logic [SET_LEN_W:0] bit_cnt_q;
   logic start_m;
   logic start_s;
   logic load;
   logic word_done;
   logic slave_abort;
   logic [FIFO_WIDTH-1:0] tx_out_data;
   logic tx_out_valid;
   logic rx_in_ready;
   logic [LVW-1:0] tx_level;
   logic [LVW-1:0] rx_level;
   logic overrun_q;
   logic irq_q;

   // =====================================================
   // FIFOs
   ssp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH_P)) tx_fifo (
      .core_clk(core_clk),
      .reset(reset),
      .in_data(tx_data),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .out_data(tx_out_data),
      .out_valid(tx_out_valid),
      .out_ready(load),
      .level(tx_level)
   );

   ssp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH_P)) rx_fifo (
      .core_clk(core_clk),
      .reset(reset),
      .in_data(shift_d),
      .in_valid(word_done),
      .in_ready(rx_in_ready),
      .out_data(rx_data),
      .out_valid(rx_valid),
      .out_ready(rx_ready),
      .level(rx_level)
   );

   // =====================================================
   // mode and settings selection
   assign mode = op_mode_t'(per_target_settings[0][SET_MODE_LSB +: 2]);
   assign slave = mode[1];
   assign seq_mode = (mode == MODE_MASTER_SEQ);
   assign next_tgt = seq_mode ? target_q : normal_target;
   assign start_set = slave ? per_target_settings[0] : per_target_settings[next_tgt];
   assign len_raw = start_set[SET_LEN_LSB +: SET_LEN_W];
   assign len_next = (len_raw < LEN_M1_MIN) ? LEN_M1_MIN : len_raw;

   // =====================================================
   // pin synchronisers: sclk, select zero, data in
   assign select_line_zero = target_select_line_in[0];
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sync1_q <= {1'b1, 1'b1, SCLK_IDLE};
         sync2_q <= {1'b1, 1'b1, SCLK_IDLE};
         sclk_d3_q <= SCLK_IDLE;
      end else begin
         sync1_q <= {serial_data_in_pin, select_line_zero, sclk_in};
         sync2_q <= sync1_q;
         sclk_d3_q <= sync2_q[0];
      end
   end

   // slave edges assume sclk at a quarter of core clock
   assign s_rise = sync2_q[0] && !sclk_d3_q;
   assign s_fall = !sync2_q[0] && sclk_d3_q;

   // =====================================================
   // prescaler and bit-rate divider
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         presc_q <= '0;
         div_q <= '0;
      end else if (state_q == ST_IDLE) begin
         presc_q <= '0;
         div_q <= '0;
      end else if (presc_q == prescale) begin
         presc_q <= '0;
         div_q <= (div_q == bit_rate_div) ? '0 : div_q + 1'b1;
      end else begin
         presc_q <= presc_q + 1'b1;
      end
   end

   // half a serial period is at least one core cycle
   assign tick = (presc_q == prescale) && (div_q == bit_rate_div) && (state_q != ST_IDLE);
   assign sclk_run = (state_q == ST_SHIFT) || ((state_q == ST_LEAD) && fp_q);

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sclk_q <= SCLK_IDLE;
      end else if (state_q == ST_IDLE) begin
         sclk_q <= SCLK_IDLE;
      end else if (tick && sclk_run) begin
         sclk_q <= ~sclk_q;
      end
   end

   assign m_rise = tick && sclk_run && !sclk_q;
   assign m_fall = tick && sclk_q;
   assign rise_e = slave ? s_rise : m_rise;
   assign fall_e = slave ? s_fall : m_fall;

   // =====================================================
   // shifter: sample on rising, shift on falling
   assign din_eff = loopback_en ? shift_q[FIFO_WIDTH-1] : sync2_q[2];
   assign shift_d = {shift_q[FIFO_WIDTH-2:0], sample_q};

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         shift_q <= '0;
      end else if (load) begin
         shift_q <= tx_out_valid ? tx_out_data << (4'(FIFO_WIDTH - 1) - len_next) : '0;
      end else if ((state_q == ST_SHIFT) && fall_e) begin
         shift_q <= shift_d;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sample_q <= 1'b0;
      end else if (rise_e) begin
         sample_q <= din_eff;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         bit_cnt_q <= '0;
      end else if (load) begin
         bit_cnt_q <= '0;
      end else if ((state_q == ST_SHIFT) && fall_e) begin
         bit_cnt_q <= bit_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         len_m1_q <= LEN_M1_MIN;
         fp_q <= 1'b0;
      end else if (load) begin
         len_m1_q <= len_next;
         fp_q <= start_set[SET_FMT_BIT];
      end
   end

   // =====================================================
   // transfer sequencing
   assign start_m = !slave && port_enable && tx_out_valid && (state_q == ST_IDLE);
   assign start_s = slave && port_enable && (state_q == ST_IDLE) &&
      (start_set[SET_FMT_BIT] ? (s_fall && sync2_q[1]) : !sync2_q[1]);
   assign load = start_m || start_s;
   assign word_done = (state_q == ST_SHIFT) && fall_e && (bit_cnt_q == {1'b0, len_m1_q});
   assign slave_abort = slave && !fp_q && sync2_q[1] && (state_q == ST_SHIFT);

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state_q <= ST_IDLE;
      end else if (!port_enable) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (start_m) begin
                  state_q <= ST_LEAD;
               end else if (start_s) begin
                  state_q <= ST_SHIFT;
               end
            end
            ST_LEAD: begin
               if (fp_q ? m_fall : tick) begin
                  state_q <= ST_SHIFT;
               end
            end
            ST_SHIFT: begin
               if (slave_abort) begin
                  state_q <= ST_IDLE;
               end else if (word_done) begin
                  state_q <= slave ? ST_IDLE : ST_TRAIL;
               end
            end
            ST_TRAIL: begin
               if (tick) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         target_q <= '0;
      end else if (start_m) begin
         target_q <= next_tgt;
      end else if (seq_mode && (state_q == ST_TRAIL) && tick) begin
         target_q <= (target_q == last_seq_target) ? '0 : target_q + 1'b1;
      end
   end

   // =====================================================
   // pins
   assign sclk_out = sclk_q;
   assign sclk_oe = !slave;
   assign serial_data_out_pin = shift_q[FIFO_WIDTH-1];

   for (genvar i = 0; i < NUM_TARGETS; i++) begin : g_sel
      logic hit;
      assign hit = !slave && (target_q == TGT_W'(i)) && (state_q != ST_IDLE);
      assign target_select_line_out[i] = fp_q ? (hit && (state_q == ST_LEAD)) : !hit;
      assign target_select_line_oe[i] = !slave;
   end

   // =====================================================
   // status and interrupt
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         overrun_q <= 1'b0;
      end else if (word_done && !rx_in_ready) begin
         overrun_q <= 1'b1;
      end else if (overrun_clear) begin
         overrun_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= (tx_irq_en && (tx_level <= LVW'(FIFO_IRQ_LEVEL))) ||
            (rx_irq_en && (rx_level >= LVW'(FIFO_IRQ_LEVEL))) ||
            (overrun_irq_en && overrun_q);
      end
   end

   assign combined_irq_out = irq_q;
   assign overrun_flag = overrun_q;
   assign busy = (state_q != ST_IDLE);

   // =====================================================
   // checks
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);

   sclk_half_rate_a: assert property (!slave && $changed(sclk_q) && $past(state_q) != ST_IDLE |-> $past(tick))
      else $error("master sclk toggled without a divider tick");

   word_length_a: assert property (word_done |-> bit_cnt_q >= 5'(MIN_WORD_LEN - 1))
      else $error("word shorter than minimum length");

   overrun_set_a: assert property (word_done && !rx_in_ready |=> overrun_q)
      else $error("overrun not recorded");

   irq_combine_a: assert property (overrun_irq_en && overrun_q |=> combined_irq_out)
      else $error("unmasked overrun did not raise interrupt");

   irq_mask_a: assert property (!tx_irq_en && !rx_irq_en && !overrun_irq_en |=> !combined_irq_out)
      else $error("interrupt raised while all sources masked");

   loopback_path_a: assert property (loopback_en && rise_e |=> sample_q == $past(shift_q[FIFO_WIDTH-1]))
      else $error("loopback bit not returned");

   spi_select_a: assert property (!slave && !fp_q && state_q == ST_SHIFT |->
      !target_select_line_out[target_q])
      else $error("spi select not low during frame");

   pin_direction_a: assert property ($past(slave) && slave |-> !sclk_oe && target_select_line_oe == '0)
      else $error("pins driven in slave mode");

   slave_select_a: assert property (slave && !fp_q && state_q == ST_SHIFT && sync2_q[1] |=>
      state_q == ST_IDLE)
      else $error("slave kept shifting without select zero");

   seq_advance_a: assert property (seq_mode && state_q == ST_TRAIL && tick && target_q != last_seq_target
      |=> target_q == $past(target_q) + 1'b1)
      else $error("sequential target did not advance");
endmodule

// ===== tb/ssp_peer.sv
// =====================================
// spi mode 0 target that answers the master
module ssp_peer (
   input wire logic sclk,
   input wire logic sel_n,
   input wire logic mosi,
   input wire logic [15:0] reply,
   input wire logic [4:0] len,
   output logic miso,
   output logic [15:0] got
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] sh;
   initial begin
      miso = 1'b0;
      got = 16'h0000;
      sh = 16'h0000;
   end
   // reply loaded msb-aligned at select
   always @(negedge sel_n) begin
      sh = reply << (16 - len);
      miso = sh[15];
      got = 16'h0000;
   end
   always @(posedge sclk) begin
      if (!sel_n) got = {got[14:0], mosi};
   end
   always @(negedge sclk) begin
      if (!sel_n) begin
         sh = sh << 1;
         miso = sh[15];
      end
   end
   // released line never keeps its last value
   always @(posedge sel_n) miso = ~miso;
endmodule

// ===== tb/synchronous_serial_port_tb.sv
module synchronous_serial_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ssp_pkg::*;
   logic core_clk = 1'b0, reset = 1'b1, port_enable = 1'b0, loopback_en = 1'b0;
   logic [7:0] prescale = 8'h00, bit_rate_div = 8'h03;
   logic [SET_W-1:0] settings [NUM_TARGETS];
   logic [TGT_W-1:0] normal_target = 2'h0, last_seq_target = 2'h0;
   logic [15:0] tx_data = 16'h0000, reply = 16'h0000, rx_data, got;
   logic tx_valid = 1'b0, rx_ready = 1'b0, tx_irq_en = 1'b0, rx_irq_en = 1'b0;
   logic overrun_irq_en = 1'b0, overrun_clear = 1'b0;
   logic tx_ready, rx_valid, overrun_flag, busy, irq, sclk_out, sclk_oe, miso, sdo;
   logic [3:0] sel_out, sel_oe, seen_low, seen_high;
   logic m_sclk = 1'b0, m_sdo = 1'b0, slave_on = 1'b0;
   logic [3:0] m_sel = 4'hf;
   logic [4:0] plen = 5'h08;
   int n_fail = 0, checked = 0;
   always #10 core_clk = ~core_clk;
   synchronous_serial_port synchronous_serial_port_inst (.core_clk(core_clk), .reset(reset),
      .port_enable(port_enable), .loopback_en(loopback_en), .prescale(prescale), .bit_rate_div(bit_rate_div),
      .per_target_settings(settings), .normal_target(normal_target), .last_seq_target(last_seq_target),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .tx_irq_en(tx_irq_en), .rx_irq_en(rx_irq_en), .overrun_irq_en(overrun_irq_en),
      .overrun_clear(overrun_clear), .overrun_flag(overrun_flag), .busy(busy), .combined_irq_out(irq),
      .sclk_in(m_sclk), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .target_select_line_in(m_sel),
      .target_select_line_out(sel_out), .target_select_line_oe(sel_oe),
      .serial_data_in_pin(slave_on ? m_sdo : miso), .serial_data_out_pin(sdo));
   ssp_peer ssp_peer_inst (.sclk(sclk_out), .sel_n(&sel_out), .mosi(sdo), .reply(reply), .len(plen),
      .miso(miso), .got(got));
   always @(posedge core_clk) begin
      seen_low <= seen_low | (~sel_out & sel_oe);
      seen_high <= seen_high | (sel_out & sel_oe);
   end
   // =====================================
   // shared tasks
   task automatic end_of_test;
      if (n_fail == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic push(input logic [15:0] w);
      int k;
      k = 0;
      while (tx_ready !== 1'b1 && k < 5000) begin
         @(negedge core_clk);
         k++;
      end
      if (k >= 5000) chk(16'(k), 16'h0000);
      tx_data = w;
      tx_valid = 1'b1;
      @(negedge core_clk);
      tx_valid = 1'b0;
      @(negedge core_clk);
   endtask
   task automatic idle;
      int k;
      repeat (3) @(negedge core_clk);
      k = 0;
      while (busy !== 1'b0 && k < 5000) begin
         @(negedge core_clk);
         k++;
      end
      if (k >= 5000) chk(16'(k), 16'h0000);
   endtask
   task automatic pop(input logic [15:0] e);
      chk(16'(rx_valid), 16'h0001);
      chk(rx_data, e);
      rx_ready = 1'b1;
      @(negedge core_clk);
      rx_ready = 1'b0;
      @(negedge core_clk);
   endtask
   // =====================================
   // scenarios
   task automatic spi(input logic [1:0] t, input int len, input logic [15:0] w, input logic [15:0] r);
      logic [15:0] m;
      m = 16'((32'h1 << len) - 1);
      settings[t] = 7'(len - 1);
      normal_target = t;
      reply = r;
      plen = 5'(len);
      seen_low = 4'h0;
      push(w);
      idle;
      chk(got & m, w & m);
      chk(16'(seen_low), 16'(4'h1 << t));
      chk(16'({sel_oe, sclk_oe}), 16'h001f);
      chk(16'(sel_out), 16'h000f);
      pop(r & m);
   endtask
   task automatic rate;
      int n, m, k;
      prescale = 8'h01;
      bit_rate_div = 8'h02;
      normal_target = 2'h0;
      settings[0] = 7'h07;
      plen = 5'h08;
      reply = 16'h005a;
      push(16'h00c3);
      k = 0;
      while (sclk_out !== 1'b1 && k < 500) begin
         @(negedge core_clk);
         k++;
      end
      n = 0;
      while (sclk_out === 1'b1 && n < 500) begin
         @(negedge core_clk);
         n++;
      end
      m = 0;
      while (sclk_out === 1'b0 && m < 500) begin
         @(negedge core_clk);
         m++;
      end
      chk(16'(n), 16'h0006);
      chk(16'(m), 16'h0006);
      idle;
      pop(16'h005a);
      prescale = 8'h00;
      bit_rate_div = 8'h03;
   endtask
   task automatic seq;
      settings[0] = {2'h1, 1'b0, 4'h7};
      last_seq_target = 2'h2;
      settings[1] = 7'h07;
      reply = 16'h00a6;
      for (int i = 0; i < 4; i++) begin
         seen_low = 4'h0;
         push(16'(i));
         idle;
         chk(16'(seen_low), 16'(4'h1 << (i % 3)));
         pop(16'h00a6);
      end
   endtask
   task automatic frame;
      settings[0] = {2'h0, 1'b1, 4'hb};
      loopback_en = 1'b1;
      push(16'h0abc);
      seen_high = 4'h0;
      idle;
      chk(16'(seen_high), 16'h0001);
      pop(16'h0abc);
      loopback_en = 1'b0;
   endtask
   task automatic overrun;
      int k;
      settings[0] = 7'h03;
      loopback_en = 1'b1;
      rx_irq_en = 1'b1;
      for (int i = 0; i < 33; i++) push(16'(i & 15));
      k = 0;
      while (overrun_flag !== 1'b1 && k < 5000) begin
         @(negedge core_clk);
         k++;
      end
      idle;
      chk(16'(overrun_flag), 16'h0001);
      chk(16'(irq), 16'h0001);
      rx_irq_en = 1'b0;
      repeat (2) @(negedge core_clk);
      chk(16'(irq), 16'h0000);
      overrun_irq_en = 1'b1;
      repeat (2) @(negedge core_clk);
      chk(16'(irq), 16'h0001);
      overrun_clear = 1'b1;
      @(negedge core_clk);
      overrun_clear = 1'b0;
      repeat (2) @(negedge core_clk);
      chk(16'({overrun_flag, irq}), 16'h0000);
      tx_irq_en = 1'b1;
      repeat (2) @(negedge core_clk);
      chk(16'(irq), 16'h0001);
      tx_irq_en = 1'b0;
      overrun_irq_en = 1'b0;
      for (int i = 0; i < 32; i++) pop(16'(i & 15));
      chk(16'(rx_valid), 16'h0000);
      loopback_en = 1'b0;
   endtask
   task automatic slave;
      logic [7:0] w, rd;
      w = 8'h5a;
      rd = 8'h00;
      settings[0] = {2'h2, 1'b0, 4'h7};
      slave_on = 1'b1;
      push(16'h0096);
      m_sel = 4'b0100;
      repeat (6) @(negedge core_clk);
      chk(16'({sel_oe, sclk_oe}), 16'h0000);
      // four kernel cycles per serial clock
      for (int i = 7; i >= 0; i--) begin
         m_sdo = w[i];
         repeat (2) @(negedge core_clk);
         m_sclk = 1'b1;
         repeat (2) @(negedge core_clk);
         rd = {rd[6:0], sdo};
         m_sclk = 1'b0;
      end
      repeat (6) @(negedge core_clk);
      m_sel = 4'hf;
      repeat (4) @(negedge core_clk);
      chk(16'(rd), 16'h0096);
      pop(16'h005a);
      slave_on = 1'b0;
   endtask
   // =====================================
   // main sequence and watchdog
   initial begin
      for (int i = 0; i < NUM_TARGETS; i++) settings[i] = 7'h07;
      seen_low = 4'h0;
      seen_high = 4'h0;
      repeat (20) @(negedge core_clk);
      chk(16'({tx_ready, rx_valid, busy, irq, overrun_flag, sclk_out}), 16'h0020);
      reset = 1'b0;
      port_enable = 1'b1;
      @(negedge core_clk);
      spi(2'h0, 4, 16'h000a, 16'h0005);
      spi(2'h0, 16, 16'hc35a, 16'h96e1);
      spi(2'h1, 12, 16'h0a5c, 16'h03c6);
      rate;
      seq;
      frame;
      overrun;
      slave;
      end_of_test;
   end
   initial begin
      repeat (40000) @(posedge core_clk);
      n_fail++;
      end_of_test;
   end
endmodule
